// file: brc_pkg.sv
// Constants and carrier types for the bridge control configuration slice.
// Assumes a 4 KB configuration space reached over AXI4-Lite with 32-bit data.
package brc_pkg;
   localparam int BRC_AW = 12;
   localparam logic [11:0] BRC_OFS_CAP_PTR = 12'h034;
   localparam logic [11:0] BRC_OFS_IRQ_CTL = 12'h03c;
   localparam logic [11:0] BRC_OFS_PM_CAP = 12'h080;
   localparam logic [7:0] BRC_CAP_PTR_VAL = 8'h80;
   localparam logic [7:0] BRC_PM_CAP_ID = 8'h01;
   localparam logic [7:0] BRC_NXT_UP = 8'h9c;
   localparam logic [7:0] BRC_NXT_DN = 8'h8c;
   localparam logic [7:0] BRC_IPIN_RST = 8'h00;
   localparam logic [15:0] BRC_CTL_RST = 16'h0000;
   // Bit positions inside the bridge control halfword (dword bits 31:16)
   localparam int BRC_BIT_PERR = 0;
   localparam int BRC_BIT_SERR = 1;
   localparam int BRC_BIT_ISA = 2;
   localparam int BRC_BIT_VGA = 3;
   localparam int BRC_BIT_VGA16 = 4;
   localparam int BRC_BIT_SBR = 6;
   localparam logic [15:0] BRC_CTL_WMASK = 16'h005f;
   localparam logic [15:0] BRC_CTL_VGA_MASK = 16'h0018;
   localparam logic [15:0] BRC_CTL_LEGACY_MASK = 16'hffa0;
   localparam logic [9:0] BRC_VGA_IO_A_LO = 10'h3b0;
   localparam logic [9:0] BRC_VGA_IO_A_HI = 10'h3bb;
   localparam logic [9:0] BRC_VGA_IO_B_LO = 10'h3c0;
   localparam logic [9:0] BRC_VGA_IO_B_HI = 10'h3df;
   localparam logic [31:0] BRC_VGA_MEM_LO = 32'h000a_0000;
   localparam logic [31:0] BRC_VGA_MEM_HI = 32'h000b_ffff;
   localparam logic [1:0] BRC_RESP_OKAY = 2'h0;
   localparam logic [1:0] BRC_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [31:0] io_addr;
      logic io_in_window;
      logic [31:0] mem_addr;
   } brc_fwd_req_type;

   typedef struct packed {
      logic io_fwd_down;
      logic io_fwd_up;
      logic vga_io_hit;
      logic vga_mem_hit;
   } brc_fwd_dec_type;
endpackage : brc_pkg

// file: brc_regs.sv
// Bridge control, interrupt pin and power-management capability header registers.
// Assumes an AXI4-Lite master on aclk and forwarding requests from same-clock logic.
`timescale 1ns/100ps
module brc_regs #(
   parameter bit IS_UPSTREAM = 1'b1,
   parameter int PORT_NUM = 0,
   parameter int NUM_DOWN = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [brc_pkg::BRC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [brc_pkg::BRC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire brc_pkg::brc_fwd_req_type fwd_req,
   output brc_pkg::brc_fwd_dec_type fwd_dec,
   input wire logic err_msg_in,
   output logic err_msg_fwd,
   input wire logic poison_in,
   output logic poison_report,
   input wire logic ipin_load_valid,
   input wire logic [7:0] ipin_load_value,
   output logic port_hot_reset,
   output logic [NUM_DOWN-1:0] downstream_reset_line_n
);
   import brc_pkg::*;

   // Port two has no video routing, so the VGA bits never store a one
   localparam logic [15:0] CTL_WMASK_EFF = (PORT_NUM == 2) ?
      (BRC_CTL_WMASK & ~BRC_CTL_VGA_MASK) : BRC_CTL_WMASK;
   localparam logic [7:0] NXT_PTR = IS_UPSTREAM ? BRC_NXT_UP : BRC_NXT_DN;

   logic [15:0] ctl_ff;
   logic [7:0] ipin_ff;
   logic [BRC_AW-1:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic [BRC_AW-1:0] ar_addr_ff;
   logic rd_go_ff;
   logic do_wr;
   logic wr_ctl;
   logic [15:0] wr_mask;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   brc_fwd_dec_type nxt_fwd_dec;
   logic [NUM_DOWN-1:0] rst_line_n_ff;

   // Write address and data are taken independently, then applied together
   assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_addr_ff <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_addr_ff <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_data_ff <= '0;
         w_strb_ff <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_data_ff <= s_axi_wdata;
         w_strb_ff <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_comb begin
      wr_hit = 1'b0;
      case ({aw_addr_ff[BRC_AW-1:2], 2'b00})
         BRC_OFS_CAP_PTR: wr_hit = 1'b1;
         BRC_OFS_IRQ_CTL: wr_hit = 1'b1;
         BRC_OFS_PM_CAP: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= BRC_RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? BRC_RESP_OKAY : BRC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only the control halfword takes data; everything else in the dword is dropped
   assign wr_ctl = do_wr && ({aw_addr_ff[BRC_AW-1:2], 2'b00} == BRC_OFS_IRQ_CTL);
   assign wr_mask = CTL_WMASK_EFF & {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_ff <= BRC_CTL_RST;
      end else if (wr_ctl) begin
         ctl_ff <= (ctl_ff & ~wr_mask) | (w_data_ff[31:16] & wr_mask);
      end
   end

   // Interrupt pin is never written by configuration; only the load port moves it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ipin_ff <= BRC_IPIN_RST;
      end else if (!IS_UPSTREAM && ipin_load_valid) begin
         ipin_ff <= ipin_load_value;
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case ({ar_addr_ff[BRC_AW-1:2], 2'b00})
         BRC_OFS_CAP_PTR: rd_word = {24'h00_0000, BRC_CAP_PTR_VAL};
         BRC_OFS_IRQ_CTL: rd_word = {ctl_ff, ipin_ff, 8'h00};
         BRC_OFS_PM_CAP: rd_word = {16'h0000, NXT_PTR, BRC_PM_CAP_ID};
         default: rd_hit = 1'b0;
      endcase
   end

   // Read data is sampled one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         ar_addr_ff <= '0;
         rd_go_ff <= 1'b0;
      end else begin
         rd_go_ff <= s_axi_arvalid && s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            ar_addr_ff <= s_axi_araddr;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= BRC_RESP_OKAY;
      end else if (rd_go_ff) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? BRC_RESP_OKAY : BRC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Forwarding decisions, one cycle behind the request
   always_comb begin
      logic low64k;
      logic isa_alias;
      logic vga_io_range;
      logic vga_io_upper;
      low64k = 1'b0;
      isa_alias = 1'b0;
      vga_io_range = 1'b0;
      vga_io_upper = 1'b0;
      low64k = (fwd_req.io_addr[31:16] == 16'h0000);
      isa_alias = low64k && (fwd_req.io_addr[9:8] != 2'b00);
      nxt_fwd_dec.io_fwd_down = fwd_req.io_in_window && !(ctl_ff[BRC_BIT_ISA] && isa_alias);
      nxt_fwd_dec.io_fwd_up = fwd_req.io_in_window && ctl_ff[BRC_BIT_ISA] && isa_alias;
      vga_io_range = ((fwd_req.io_addr[9:0] >= BRC_VGA_IO_A_LO) && (fwd_req.io_addr[9:0] <= BRC_VGA_IO_A_HI)) ||
                     ((fwd_req.io_addr[9:0] >= BRC_VGA_IO_B_LO) && (fwd_req.io_addr[9:0] <= BRC_VGA_IO_B_HI));
      // 10-bit mode lets aliases above 3FFh hit as well
      vga_io_upper = low64k && (!ctl_ff[BRC_BIT_VGA16] || (fwd_req.io_addr[15:10] == 6'h00));
      nxt_fwd_dec.vga_io_hit = ctl_ff[BRC_BIT_VGA] && vga_io_range && vga_io_upper;
      nxt_fwd_dec.vga_mem_hit = ctl_ff[BRC_BIT_VGA] && (fwd_req.mem_addr >= BRC_VGA_MEM_LO) &&
                                (fwd_req.mem_addr <= BRC_VGA_MEM_HI);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fwd_dec <= '0;
      end else begin
         fwd_dec <= nxt_fwd_dec;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_msg_fwd <= 1'b0;
         poison_report <= 1'b0;
      end else begin
         err_msg_fwd <= err_msg_in && ctl_ff[BRC_BIT_SERR];
         poison_report <= poison_in && ctl_ff[BRC_BIT_PERR];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_hot_reset <= 1'b0;
      end else begin
         port_hot_reset <= ctl_ff[BRC_BIT_SBR];
      end
   end

   // A downstream instance drives only its first line; the rest stay released
   for (genvar i = 0; i < NUM_DOWN; i++) begin : g_rst
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            rst_line_n_ff[i] <= 1'b1;
         end else if (IS_UPSTREAM || (i == 0)) begin
            rst_line_n_ff[i] <= !ctl_ff[BRC_BIT_SBR];
         end else begin
            rst_line_n_ff[i] <= 1'b1;
         end
      end
   end
   assign downstream_reset_line_n = rst_line_n_ff;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [NUM_DOWN-1:0] exp_rst_n;
   for (genvar j = 0; j < NUM_DOWN; j++) begin : g_exp
      assign exp_rst_n[j] = (IS_UPSTREAM || (j == 0)) ? 1'b0 : 1'b1;
   end

   chk_poison_gate: assert property (poison_report |-> $past(poison_in) && $past(ctl_ff[BRC_BIT_PERR]))
      else $error("poison report without enable");
   chk_err_gate: assert property (err_msg_fwd == ($past(err_msg_in) && $past(ctl_ff[BRC_BIT_SERR])))
      else $error("error message forwarding mismatch");
   chk_isa_alias_up: assert property (ctl_ff[BRC_BIT_ISA] && fwd_req.io_in_window &&
      fwd_req.io_addr[31:16] == 16'h0000 && fwd_req.io_addr[9:8] != 2'b00 && $stable(ctl_ff)
      |=> fwd_dec.io_fwd_up && !fwd_dec.io_fwd_down)
      else $error("isa alias not sent upstream");
   chk_isa_off_down: assert property (!ctl_ff[BRC_BIT_ISA] && fwd_req.io_in_window && $stable(ctl_ff)
      |=> fwd_dec.io_fwd_down && !fwd_dec.io_fwd_up)
      else $error("window address not forwarded downstream");
   chk_vga_mem_hit: assert property (fwd_dec.vga_mem_hit |-> $past(ctl_ff[BRC_BIT_VGA]) &&
      $past(fwd_req.mem_addr) >= 32'h000a_0000 && $past(fwd_req.mem_addr) <= 32'h000b_ffff)
      else $error("vga memory hit outside range");
   chk_vga_io_16: assert property (fwd_dec.vga_io_hit && $past(ctl_ff[BRC_BIT_VGA16])
      |-> $past(fwd_req.io_addr[15:10]) == 6'h00)
      else $error("16-bit vga decode matched alias");
   chk_vga_port2: assert property ((PORT_NUM == 2) |-> ctl_ff[BRC_BIT_VGA16:BRC_BIT_VGA] == 2'b00)
      else $error("vga bits stored on port two");
   chk_sbr_lines: assert property (ctl_ff[BRC_BIT_SBR] ##1 ctl_ff[BRC_BIT_SBR]
      |-> port_hot_reset && downstream_reset_line_n == exp_rst_n)
      else $error("reset lines not asserted with secondary bus reset");
   chk_sbr_release: assert property (!ctl_ff[BRC_BIT_SBR] |=> !port_hot_reset &&
      downstream_reset_line_n == {NUM_DOWN{1'b1}})
      else $error("reset lines not released");
   chk_ctl_read: assert property (s_axi_rvalid && s_axi_rresp == BRC_RESP_OKAY &&
      {ar_addr_ff[BRC_AW-1:2], 2'b00} == BRC_OFS_IRQ_CTL
      |-> (s_axi_rdata[31:16] & BRC_CTL_LEGACY_MASK) == 16'h0000 && s_axi_rdata[7:0] == 8'h00)
      else $error("legacy or reserved control bits read nonzero");
   chk_cap_read: assert property (s_axi_rvalid && {ar_addr_ff[BRC_AW-1:2], 2'b00} == BRC_OFS_PM_CAP
      |-> s_axi_rdata == {16'h0000, NXT_PTR, 8'h01})
      else $error("capability header read wrong");
   chk_cap_ptr: assert property (s_axi_rvalid && {ar_addr_ff[BRC_AW-1:2], 2'b00} == BRC_OFS_CAP_PTR
      |-> s_axi_rdata == 32'h0000_0080)
      else $error("capability pointer read wrong");
   chk_ipin_hold: assert property (!(ipin_load_valid && !IS_UPSTREAM) |=> $stable(ipin_ff))
      else $error("interrupt pin changed without a load");
   chk_ctl_hold: assert property (!wr_ctl |=> $stable(ctl_ff))
      else $error("control changed without a write");

   // Handshake discipline on the register bus
   // A response that drops before it is accepted hangs the master,
   // so every answer must stand until its ready is seen
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before accept");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped before accept");
   chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read answer not two cycles after address");
   chk_wr_answer: assert property (do_wr |=> s_axi_bvalid)
      else $error("write response missing after write");
   chk_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write accepted before response");
   chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("new read accepted before response");
   chk_bus_reopen: assert property (s_axi_bvalid && s_axi_bready
      |=> s_axi_awready && s_axi_wready && !s_axi_bvalid)
      else $error("write channels not reopened");
   chk_rd_reopen: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
      else $error("read channel not reopened");
   chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == BRC_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   // Stored control state never holds a bit that software cannot set
   chk_ctl_reserved: assert property ((ctl_ff & ~CTL_WMASK_EFF) == 16'h0000)
      else $error("reserved control bit stored");
   chk_ipin_upstream: assert property (IS_UPSTREAM |-> ipin_ff == BRC_IPIN_RST)
      else $error("upstream interrupt pin moved");
   chk_ipin_load: assert property (!IS_UPSTREAM && ipin_load_valid |=> ipin_ff == $past(ipin_load_value))
      else $error("interrupt pin load not applied");
   chk_hot_follow: assert property (port_hot_reset == $past(ctl_ff[BRC_BIT_SBR]))
      else $error("hot reset does not follow control bit");

   // Gating: a clear enable must block the event in the next cycle
   chk_err_off: assert property (!ctl_ff[BRC_BIT_SERR] |=> !err_msg_fwd)
      else $error("error message forwarded while disabled");
   chk_poison_off: assert property (!ctl_ff[BRC_BIT_PERR] |=> !poison_report)
      else $error("poison reported while disabled");
   chk_vga_off: assert property (!ctl_ff[BRC_BIT_VGA] |=> !fwd_dec.vga_io_hit && !fwd_dec.vga_mem_hit)
      else $error("vga hit while disabled");
   chk_fwd_exclusive: assert property (!(fwd_dec.io_fwd_up && fwd_dec.io_fwd_down))
      else $error("io forwarded both ways");
   chk_vga_io_low64k: assert property (fwd_dec.vga_io_hit |-> $past(fwd_req.io_addr[31:16]) == 16'h0000)
      else $error("vga io hit above 64KB");
   // 10-bit mode must still match aliases whose upper bits are set
   chk_vga_io_10: assert property (ctl_ff[BRC_BIT_VGA] && !ctl_ff[BRC_BIT_VGA16] &&
      fwd_req.io_addr[31:16] == 16'h0000 && fwd_req.io_addr[9:0] >= BRC_VGA_IO_B_LO &&
      fwd_req.io_addr[9:0] <= BRC_VGA_IO_B_HI |=> fwd_dec.vga_io_hit)
      else $error("10-bit vga decode missed");
   chk_vga_mem_in: assert property (ctl_ff[BRC_BIT_VGA] && fwd_req.mem_addr >= BRC_VGA_MEM_LO &&
      fwd_req.mem_addr <= BRC_VGA_MEM_HI |=> fwd_dec.vga_mem_hit)
      else $error("vga memory access not forwarded");

   cov_sbr_pulse: cover property (!ctl_ff[BRC_BIT_SBR] ##1 ctl_ff[BRC_BIT_SBR] [*3] ##1 !ctl_ff[BRC_BIT_SBR]);
   cov_vga_io: cover property (fwd_dec.vga_io_hit);
   cov_err_fwd: cover property (err_msg_fwd);
   cov_isa_up: cover property (fwd_dec.io_fwd_up);
   cov_rd_slverr: cover property (s_axi_rvalid && s_axi_rresp == BRC_RESP_SLVERR);
endmodule : brc_regs

// file: brc_rc_model.sv
// Root complex stand-in issuing configuration reads and writes as an AXI4-Lite master.
// Assumes the slave shares aclk; tasks are called from one process, one transfer at a time.
`timescale 1ns/100ps
module brc_rc_model (
   input wire logic aclk,
   output logic [brc_pkg::BRC_AW-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [brc_pkg::BRC_AW-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   import brc_pkg::*;
   // Cycles after the request before ready is raised; a value above 2 makes the slave hold its answer
   int lag = 0;
   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (lag == 0);
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
         if (n >= lag) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (lag == 0);
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
         if (n >= lag) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : brc_rc_model

// file: testbench.sv
// Self-checking bench for the bridge control register slice, upstream instance.
// Assumes brc_pkg, brc_regs and brc_rc_model are compiled first.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
   import brc_pkg::*;
   typedef struct packed {
      logic [4:0] ctl;
      logic [31:0] io;
      logic win;
      logic [31:0] mem;
      logic [3:0] dec;
   } brc_row_type;
   logic aclk, aresetn, err_msg_in, err_msg_fwd, poison_in, poison_report, ipin_load_valid, port_hot_reset;
   logic [7:0] ipin_load_value;
   logic [3:0] downstream_reset_line_n, s_axi_wstrb;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   brc_fwd_req_type fwd_req;
   brc_fwd_dec_type fwd_dec;
   int error_cnt = 0;
   int total_checks = 0;
   // Control bits {vga16, vga, isa, err fwd, poison}; decision {down, up, vga io, vga mem}
   brc_row_type rows [11] = '{
      '{5'h00, 32'h0000_0100, 1'b1, 32'h000a_0000, 4'h8},
      '{5'h04, 32'h0000_0100, 1'b1, 32'h0000_0000, 4'h4},
      '{5'h04, 32'h0000_0000, 1'b1, 32'h0000_0000, 4'h8},
      '{5'h04, 32'h0001_0100, 1'b1, 32'h0000_0000, 4'h8},
      '{5'h08, 32'h0000_03b0, 1'b0, 32'h000a_0000, 4'h3},
      '{5'h08, 32'h0000_03bc, 1'b0, 32'h000b_ffff, 4'h1},
      '{5'h08, 32'h0000_07df, 1'b0, 32'h000c_0000, 4'h2},
      '{5'h18, 32'h0000_07df, 1'b0, 32'h0009_ffff, 4'h0},
      '{5'h18, 32'h0000_03c0, 1'b0, 32'h0000_0000, 4'h2},
      '{5'h00, 32'h0000_03c0, 1'b0, 32'h000a_0000, 4'h0},
      '{5'h03, 32'h0000_0000, 1'b1, 32'h0000_0000, 4'h8}
   };
   brc_regs #(.IS_UPSTREAM(1'b1), .PORT_NUM(0), .NUM_DOWN(4)) dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .fwd_req, .fwd_dec, .err_msg_in, .err_msg_fwd, .poison_in, .poison_report,
      .ipin_load_valid, .ipin_load_value, .port_hot_reset, .downstream_reset_line_n
   );
   brc_rc_model rc (
      .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   task automatic results;
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (5000) @(posedge aclk);
      error_cnt++;
      results();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      {aresetn, err_msg_in, poison_in, ipin_load_valid, ipin_load_value, fwd_req} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rc.rd(BRC_OFS_IRQ_CTL, d, r);
      `CHK("irq_ctl_rst", 32'h0, d)
      rc.rd(BRC_OFS_CAP_PTR, d, r);
      `CHK("cap_ptr", 32'h0000_0080, d)
      rc.rd(BRC_OFS_PM_CAP, d, r);
      `CHK("pm_cap", 32'h0000_9c01, d)
      rc.wr(BRC_OFS_PM_CAP, 32'hffff_ffff, 4'hf, r);
      rc.rd(BRC_OFS_PM_CAP, d, r);
      `CHK("pm_cap_ro", {2'h0, 32'h0000_9c01}, {r, d})
      rc.wr(12'h100, 32'hffff_ffff, 4'hf, r);
      `CHK("wr_unmapped", BRC_RESP_SLVERR, r)
      rc.rd(12'h100, d, r);
      `CHK("rd_unmapped", {BRC_RESP_SLVERR, 32'h0}, {r, d})
      foreach (rows[i]) begin
         rc.lag = i % 3;
         rc.wr(BRC_OFS_IRQ_CTL, {11'h0, rows[i].ctl, 16'h0}, 4'hf, r);
         @(posedge aclk);
         fwd_req <= '{rows[i].io, rows[i].win, rows[i].mem};
         err_msg_in <= 1'b1;
         poison_in <= 1'b1;
         @(posedge aclk);
         err_msg_in <= 1'b0;
         poison_in <= 1'b0;
         #1;
         `CHK("fwd_dec", rows[i].dec, fwd_dec)
         `CHK("events", rows[i].ctl[1:0], {err_msg_fwd, poison_report})
         rc.rd(BRC_OFS_IRQ_CTL, d, r);
         `CHK("ctl_rd", {11'h0, rows[i].ctl, 16'h0}, d)
      end
      rc.wr(BRC_OFS_IRQ_CTL, 32'hffff_ffff, 4'h8, r);
      rc.rd(BRC_OFS_IRQ_CTL, d, r);
      `CHK("strb3_only", 32'h0003_0000, d)
      rc.wr(BRC_OFS_IRQ_CTL, 32'hffff_ffff, 4'hf, r);
      ipin_load_value <= 8'h5a;
      ipin_load_valid <= 1'b1;
      @(posedge aclk);
      ipin_load_valid <= 1'b0;
      rc.rd(BRC_OFS_IRQ_CTL, d, r);
      `CHK("all_ones", {2'h0, 32'h005f_0000}, {r, d})
      repeat (5) @(posedge aclk);
      #1;
      `CHK("hot_reset_on", 5'h10, {port_hot_reset, downstream_reset_line_n})
      rc.wr(BRC_OFS_IRQ_CTL, 32'h0, 4'h4, r);
      repeat (2) @(posedge aclk);
      #1;
      `CHK("hot_reset_off", 5'h0f, {port_hot_reset, downstream_reset_line_n})
      rc.wr(BRC_OFS_IRQ_CTL, 32'h0040_0000, 4'h4, r);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      #1;
      `CHK("lines_in_reset", 5'h0f, {port_hot_reset, downstream_reset_line_n})
      @(posedge aclk);
      aresetn <= 1'b1;
      rc.rd(BRC_OFS_IRQ_CTL, d, r);
      `CHK("ctl_after_reset", 32'h0, d)
      results();
   end
endmodule : testbench
